/* common/tio_defs.svh */
// How it works
// - mode 2: on while fout near commanded frequency
// - mode 3: on while fout within reach plus/minus band
// - mode 4: on while fout above reach frequency
// - mode 5: on while fout below reach frequency
// - mode 12: on while over-torque is active
// - mode 13: on once counter reaches top
// - five polarity bits, one per input, invert
// - input six has its own polarity bit
// - type code picks 4 mA and 2 V zeros
// - voltage scan count 1 to 100, 4 ms
// - one averaged reading per count times 4 ms
// - voltage input: gain, bias, bias sign, slope
// - current input has the same own settings
// - function bit routes current to feedback or offset
// - offset use ignores current scaling settings
// - source code selects meter output quantity
// - bus and current sources span full scale
// - meter output capped at 10 V, gain scaled
// - meter output applies bias, sign and slope
// - reach 0 to 400 Hz, band 0 to 30 Hz
`ifndef TIO_DEFS_SVH
`define TIO_DEFS_SVH
`define TIO_SCAN_NS 4000000
`define TIO_CLK_NS 40
`define TIO_SCAN_CYC (`TIO_SCAN_NS / `TIO_CLK_NS)
`define TIO_FREQ_MAX 16'd40000
`define TIO_BAND_MAX 16'd3000
`define TIO_CNT_MAX 8'd100
`define TIO_ADC_FULL 12'hfff
`define TIO_LIVE_ZERO 12'h333
`define TIO_OUT_FULL 12'hfff
`define TIO_GAIN_MAX 11'd1000
`define TIO_BIAS_MAX 11'd1000
`define TIO_A_RELAY 4'h0
`define TIO_A_XSTR 4'h1
`define TIO_A_REACH 4'h2
`define TIO_A_BAND 4'h3
`define TIO_A_POL 4'h4
`define TIO_A_AIN 4'h5
`define TIO_A_VSCL 4'h6
`define TIO_A_CSCL 4'h7
`define TIO_A_MSCL 4'h8
`define TIO_A_STAT 4'h9
`define TIO_A_VAL 4'ha
`define TIO_A_MVAL 4'hb
`endif

/* common/tio_pkg.sv */
package tio_pkg;
    typedef struct packed {
        logic [10:0] gain;
        logic [10:0] bias;
        logic bias_neg;
        logic slope_neg;
    } scale_type;
    typedef struct packed {
        logic [15:0] fout;
        logic [15:0] fset;
        logic [11:0] vout;
        logic [11:0] vbus;
        logic [11:0] iout;
    } drive_type;
    typedef enum logic [1:0] {
        MD_IDLE = 2'b00,
        MD_SUM = 2'b01,
        MD_DONE = 2'b11
    } avg_state_type;
endpackage

/* verilog/terminal_io_conditioning.sv */
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "tio_defs.svh"
module terminal_io_conditioning
    import tio_pkg::*;
#(
    parameter int SCAN_CYC = `TIO_SCAN_CYC,
    parameter int DIN_N = 6
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // drive state
    input wire drive_type i_drive,
    input wire logic i_over_torque,
    input wire logic i_count_top,
    input wire logic i_hv_class,
    // field terminals
    input wire logic [DIN_N-1:0] i_digital_inputs,
    input wire logic [11:0] i_voltage_analog_input,
    input wire logic [11:0] i_current_analog_input,
    output logic [DIN_N-1:0] o_din,
    output logic [11:0] o_volt_ref,
    output logic [11:0] o_cur_feedback,
    output logic [11:0] o_cur_offset,
    output logic [11:0] o_meter_analog_output,
    output logic o_relay_output,
    output logic o_transistor_output
);
    logic [31:0] scan_div;
    logic scan_tick;
    logic [3:0] relay_mode;
    logic [3:0] xstr_mode;
    logic [15:0] reach;
    logic [15:0] band;
    logic [5:0] pol;
    logic [7:0] din_scans;
    logic [1:0] ain_type;
    logic cur_as_offset;
    logic [7:0] v_scans;
    logic [7:0] c_scans;
    logic [2:0] meter_src;
    scale_type v_scl;
    scale_type c_scl;
    scale_type m_scl;
    logic [DIN_N-1:0] din_raw;
    logic [DIN_N-1:0] din_last;
    logic [7:0] din_run [DIN_N];
    logic [19:0] v_sum;
    logic [19:0] c_sum;
    logic [7:0] v_cnt;
    logic [7:0] c_cnt;
    avg_state_type v_state;

    // scan timebase
    assign scan_tick = (scan_div == 32'(SCAN_CYC - 1));
    always_ff @(posedge i_clk) begin
        if (i_rst || scan_tick) begin
            scan_div <= 32'h0;
        end else begin
            scan_div <= scan_div + 32'h1;
        end
    end

    // register writes
    wire wr_relay = i_wr && (i_addr == `TIO_A_RELAY);
    wire wr_xstr = i_wr && (i_addr == `TIO_A_XSTR);
    wire wr_reach = i_wr && (i_addr == `TIO_A_REACH);
    wire wr_band = i_wr && (i_addr == `TIO_A_BAND);
    wire wr_pol = i_wr && (i_addr == `TIO_A_POL);
    wire wr_ain = i_wr && (i_addr == `TIO_A_AIN);
    wire wr_vscl = i_wr && (i_addr == `TIO_A_VSCL);
    wire wr_cscl = i_wr && (i_addr == `TIO_A_CSCL);
    wire wr_mscl = i_wr && (i_addr == `TIO_A_MSCL);
    wire [15:0] w_freq = (i_wdata[15:0] > `TIO_FREQ_MAX) ?
        `TIO_FREQ_MAX : i_wdata[15:0];
    wire [15:0] w_band = (i_wdata[15:0] > `TIO_BAND_MAX) ?
        `TIO_BAND_MAX : i_wdata[15:0];
    wire [7:0] w_cnt = (i_wdata[23:16] == 8'h0) ? 8'h1 :
        (i_wdata[23:16] > `TIO_CNT_MAX) ? `TIO_CNT_MAX : i_wdata[23:16];
    wire [7:0] w_cnt2 = (i_wdata[15:8] == 8'h0) ? 8'h1 :
        (i_wdata[15:8] > `TIO_CNT_MAX) ? `TIO_CNT_MAX : i_wdata[15:8];
    wire [10:0] w_gain = (i_wdata[10:0] > `TIO_GAIN_MAX) ?
        `TIO_GAIN_MAX : i_wdata[10:0];
    wire [10:0] w_bias = (i_wdata[26:16] > `TIO_BIAS_MAX) ?
        `TIO_BIAS_MAX : i_wdata[26:16];
    wire scale_type w_scl = '{w_gain, w_bias, i_wdata[28], i_wdata[29]};

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            relay_mode <= 4'h0;
            xstr_mode <= 4'h0;
            reach <= 16'h0;
            band <= 16'h0;
            pol <= 6'h0;
            din_scans <= 8'h1;
            ain_type <= 2'h0;
            cur_as_offset <= 1'b0;
            v_scans <= 8'h1;
            c_scans <= 8'h1;
            meter_src <= 3'h0;
            v_scl <= '{11'd100, 11'd0, 1'b0, 1'b0};
            c_scl <= '{11'd100, 11'd0, 1'b0, 1'b0};
            m_scl <= '{11'd100, 11'd0, 1'b0, 1'b0};
        end else begin
            if (wr_relay) relay_mode <= i_wdata[3:0];
            if (wr_xstr) xstr_mode <= i_wdata[3:0];
            if (wr_reach) reach <= w_freq;
            if (wr_band) band <= w_band;
            if (wr_pol) begin
                pol <= i_wdata[5:0];
                din_scans <= (i_wdata[15:8] == 8'h0) ? 8'h1 : i_wdata[15:8];
            end
            if (wr_ain) begin
                ain_type <= i_wdata[1:0];
                cur_as_offset <= i_wdata[2];
                meter_src <= (i_wdata[6:4] > 3'h4) ? 3'h0 : i_wdata[6:4];
                v_scans <= w_cnt2;
                c_scans <= w_cnt;
            end
            if (wr_vscl) v_scl <= w_scl;
            if (wr_cscl) c_scl <= w_scl;
            if (wr_mscl) m_scl <= w_scl;
        end
    end

    // digital inputs: invert first, then confirm over scans
    assign din_raw = i_digital_inputs ^ pol;
    genvar gi;
    generate
        for (gi = 0; gi < DIN_N; gi++) begin : g_din
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    din_last[gi] <= 1'b0;
                    din_run[gi] <= 8'h0;
                    o_din[gi] <= 1'b0;
                end else if (scan_tick) begin
                    din_last[gi] <= din_raw[gi];
                    if (din_raw[gi] != din_last[gi]) begin
                        din_run[gi] <= 8'h1;
                    end else if (din_run[gi] != 8'hff) begin
                        din_run[gi] <= din_run[gi] + 8'h1;
                    end
                    if (din_raw[gi] == din_last[gi] &&
                        din_run[gi] + 8'h1 >= din_scans) begin
                        o_din[gi] <= din_raw[gi];
                    end
                end
            end
        end
    endgenerate

    // scaling: live zero, gain, slope, bias with sign
    function automatic logic [11:0] scale_f(input logic [11:0] raw,
        input logic live, input scale_type s);
        logic [23:0] base;
        logic [35:0] g;
        logic signed [15:0] v;
        logic signed [15:0] b;
        base = 24'h0;
        g = 36'h0;
        v = 16'sh0;
        b = 16'sh0;
        if (live) begin
            base = (raw <= `TIO_LIVE_ZERO) ? 24'h0 :
                24'((32'(raw - `TIO_LIVE_ZERO) * 32'hfff) /
                32'(`TIO_ADC_FULL - `TIO_LIVE_ZERO));
        end else begin
            base = 24'(raw);
        end
        g = (36'(base) * 36'(s.gain)) / 36'd100;
        v = (g > 36'hfff) ? 16'sh0fff : 16'(g);
        if (s.slope_neg) v = 16'sh0fff - v;
        b = 16'(32'(s.bias) * 32'hfff / 32'd1000);
        v = s.bias_neg ? v - b : v + b;
        if (v < 0) v = 16'sh0;
        if (v > 16'sh0fff) v = 16'sh0fff;
        return v[11:0];
    endfunction

    // averaging over programmed scan counts
    wire v_done = scan_tick && (v_cnt + 8'h1 >= v_scans);
    wire c_done = scan_tick && (c_cnt + 8'h1 >= c_scans);
    wire [19:0] v_tot = v_sum + 20'(i_voltage_analog_input);
    wire [19:0] c_tot = c_sum + 20'(i_current_analog_input);
    wire [11:0] v_avg = 12'(v_tot / 20'(v_scans));
    wire [11:0] c_avg = 12'(c_tot / 20'(c_scans));
    wire [11:0] c_rawavg = 12'(c_tot / 20'(v_scans));
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            v_sum <= 20'h0;
            c_sum <= 20'h0;
            v_cnt <= 8'h0;
            c_cnt <= 8'h0;
            v_state <= MD_IDLE;
            o_volt_ref <= 12'h0;
            o_cur_feedback <= 12'h0;
            o_cur_offset <= 12'h0;
        end else if (scan_tick) begin
            v_state <= v_done ? MD_DONE : MD_SUM;
            v_sum <= v_done ? 20'h0 : v_tot;
            v_cnt <= v_done ? 8'h0 : v_cnt + 8'h1;
            if (v_done) begin
                o_volt_ref <= scale_f(v_avg, ain_type[1], v_scl);
                if (cur_as_offset) begin
                    o_cur_offset <= c_rawavg;
                end
            end
            if (cur_as_offset) begin
                c_sum <= v_done ? 20'h0 : c_tot;
                c_cnt <= 8'h0;
            end else begin
                c_sum <= c_done ? 20'h0 : c_tot;
                c_cnt <= c_done ? 8'h0 : c_cnt + 8'h1;
                if (c_done) begin
                    o_cur_feedback <= scale_f(c_avg, ain_type[0],
                        c_scl);
                end
            end
        end
    end

    // relay conditions
    function automatic logic relay_f(input logic [3:0] m,
        input drive_type d, input logic [15:0] rf, input logic [15:0] bw,
        input logic ot, input logic top);
        unique case (m)
            4'd2: relay_f = (17'(d.fout) + 17'(bw) >= 17'(d.fset)) &&
                (17'(d.fout) <= 17'(d.fset) + 17'(bw));
            4'd3: relay_f = (17'(d.fout) + 17'(bw) >= 17'(rf)) &&
                (17'(d.fout) <= 17'(rf) + 17'(bw));
            4'd4: relay_f = d.fout > rf;
            4'd5: relay_f = d.fout < rf;
            4'd12: relay_f = ot;
            4'd13: relay_f = top;
            default: relay_f = 1'b0;
        endcase
    endfunction

    // meter source, full scale per source
    logic [11:0] m_raw;
    always_comb begin
        m_raw = 12'h0;
        unique case (meter_src)
            3'd0: m_raw = 12'(32'(i_drive.fout) * 32'hfff / 32'd40000);
            3'd1: m_raw = 12'(32'(i_drive.fset) * 32'hfff / 32'd40000);
            3'd2: m_raw = i_drive.vout;
            3'd3: m_raw = i_hv_class ? i_drive.vbus :
                ((i_drive.vbus > 12'h7ff) ? 12'hfff :
                12'({i_drive.vbus, 1'b0}));
            3'd4: m_raw = i_drive.iout;
            default: m_raw = 12'h0;
        endcase
    end

    // relays and meter refreshed together on each scan
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_relay_output <= 1'b0;
            o_transistor_output <= 1'b0;
            o_meter_analog_output <= 12'h0;
        end else if (scan_tick) begin
            o_relay_output <= relay_f(relay_mode, i_drive, reach, band,
                i_over_torque, i_count_top);
            o_transistor_output <= relay_f(xstr_mode, i_drive, reach, band,
                i_over_torque, i_count_top);
            o_meter_analog_output <= scale_f(m_raw, 1'b0,
                m_scl);
        end
    end

    // register reads
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= 32'h0;
        end else if (i_rd) begin
            unique case (i_addr)
                `TIO_A_RELAY: o_rdata <= {28'h0, relay_mode};
                `TIO_A_XSTR: o_rdata <= {28'h0, xstr_mode};
                `TIO_A_REACH: o_rdata <= {16'h0, reach};
                `TIO_A_BAND: o_rdata <= {16'h0, band};
                `TIO_A_POL: o_rdata <= {16'h0, din_scans, 2'h0, pol};
                `TIO_A_AIN: o_rdata <= {8'h0, c_scans, v_scans, 1'b0,
                    meter_src, 1'b0, cur_as_offset, ain_type};
                `TIO_A_VSCL: o_rdata <= {2'h0, v_scl.slope_neg,
                    v_scl.bias_neg, 1'b0, v_scl.bias, 5'h0, v_scl.gain};
                `TIO_A_CSCL: o_rdata <= {2'h0, c_scl.slope_neg,
                    c_scl.bias_neg, 1'b0, c_scl.bias, 5'h0, c_scl.gain};
                `TIO_A_MSCL: o_rdata <= {2'h0, m_scl.slope_neg,
                    m_scl.bias_neg, 1'b0, m_scl.bias, 5'h0, m_scl.gain};
                `TIO_A_STAT: o_rdata <= {24'h0, o_transistor_output,
                    o_relay_output, o_din};
                `TIO_A_VAL: o_rdata <= {4'h0, o_cur_feedback, 4'h0,
                    o_volt_ref};
                `TIO_A_MVAL: o_rdata <= {8'h0, o_cur_offset, 
                    o_meter_analog_output};
                default: o_rdata <= 32'h0;
            endcase
        end else begin
            o_rdata <= 32'h0;
        end
    end

    // checks
    AST_HOLD_RELAY: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !scan_tick |=> $stable(o_relay_output))
        else $error("relay changed off scan");
    AST_TORQUE: assert property (
        @(posedge i_clk) disable iff (i_rst)
        scan_tick && relay_mode == 4'd12 |=>
        o_relay_output == $past(i_over_torque))
        else $error("over-torque relay wrong");
    AST_ABOVE: assert property (
        @(posedge i_clk) disable iff (i_rst)
        scan_tick && relay_mode == 4'd4 |=> o_relay_output ==
        ($past(i_drive.fout) > $past(reach)))
        else $error("above-reach relay wrong");
    AST_BELOW: assert property (
        @(posedge i_clk) disable iff (i_rst)
        scan_tick && xstr_mode == 4'd5 |=> o_transistor_output ==
        ($past(i_drive.fout) < $past(reach)))
        else $error("below-reach output wrong");
    AST_TOP: assert property (
        @(posedge i_clk) disable iff (i_rst)
        scan_tick && relay_mode == 4'd13 |=>
        o_relay_output == $past(i_count_top))
        else $error("top count relay wrong");
    AST_METER_HOLD: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !scan_tick |=> $stable(o_meter_analog_output))
        else $error("meter changed off scan");
    AST_OFFSET_MODE: assert property (
        @(posedge i_clk) disable iff (i_rst)
        cur_as_offset && $past(cur_as_offset) |=> $stable(o_cur_feedback))
        else $error("feedback moved in offset mode");
    AST_REACH_MAX: assert property (
        @(posedge i_clk) disable iff (i_rst)
        reach <= `TIO_FREQ_MAX && band <= `TIO_BAND_MAX)
        else $error("reach or band out of range");
    AST_SCAN_MAX: assert property (
        @(posedge i_clk) disable iff (i_rst)
        v_scans >= 8'h1 && v_scans <= `TIO_CNT_MAX &&
        c_scans >= 8'h1 && c_scans <= `TIO_CNT_MAX)
        else $error("scan count out of range");
    COV_AVG_DONE: cover property (@(posedge i_clk) v_state == MD_DONE);
    COV_RELAY_ON: cover property (@(posedge i_clk) $rose(o_relay_output));
    COV_XSTR_ON: cover property (@(posedge i_clk)
        $rose(o_transistor_output));
    COV_DIN: cover property (@(posedge i_clk) $changed(o_din));
    COV_OFFSET: cover property (@(posedge i_clk)
        cur_as_offset && $changed(o_cur_offset));
endmodule

/* sim/field_model.sv */
`timescale 1ns/1ps
module field_model (
    // clock
    input wire logic i_clk,
    // commanded field conditions
    input wire logic [5:0] i_closed,
    input wire logic [11:0] i_volt,
    input wire logic [11:0] i_cur,
    // terminal side
    output logic [5:0] o_digital_inputs,
    output logic [11:0] o_voltage_analog_input,
    output logic [11:0] o_current_analog_input
);
    // contacts and sensors settle at the clock, like a sampled converter
    always_ff @(posedge i_clk) begin
        o_digital_inputs <= i_closed;
        o_voltage_analog_input <= i_volt;
        o_current_analog_input <= i_cur;
    end
endmodule

/* sim/terminal_io_conditioning_bench.sv */
`timescale 1ns/1ps
`include "tio_defs.svh"
module terminal_io_conditioning_bench
    import tio_pkg::*;
;
    localparam int SCAN = 10;
    localparam int SETTLE = SCAN * 12;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    drive_type drv = '0;
    logic over_torque = 1'b0;
    logic count_top = 1'b0;
    logic hv_class = 1'b0;
    logic [5:0] closed = 6'h00;
    logic [11:0] volt = 12'h000;
    logic [11:0] cur = 12'h000;
    logic [5:0] din_w;
    logic [11:0] volt_w;
    logic [11:0] cur_w;
    logic [5:0] o_din;
    logic [11:0] o_volt_ref;
    logic [11:0] o_cur_feedback;
    logic [11:0] o_cur_offset;
    logic [11:0] o_meter;
    logic o_relay;
    logic o_xstr;
    logic [31:0] rdv;
    int err_count = 0;
    int comparisons = 0;

    always #20 i_clk = ~i_clk;

    field_model i_field (.i_clk(i_clk), .i_closed(closed), .i_volt(volt),
        .i_cur(cur), .o_digital_inputs(din_w),
        .o_voltage_analog_input(volt_w), .o_current_analog_input(cur_w));

    terminal_io_conditioning #(.SCAN_CYC(SCAN), .DIN_N(6)) i_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_drive(drv),
        .i_over_torque(over_torque), .i_count_top(count_top),
        .i_hv_class(hv_class), .i_digital_inputs(din_w),
        .i_voltage_analog_input(volt_w), .i_current_analog_input(cur_w),
        .o_din(o_din), .o_volt_ref(o_volt_ref),
        .o_cur_feedback(o_cur_feedback), .o_cur_offset(o_cur_offset),
        .o_meter_analog_output(o_meter), .o_relay_output(o_relay),
        .o_transistor_output(o_xstr));

    task automatic end_of_test;
        if (err_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        rdv = o_rdata;
        chk(rdv, exp);
    endtask

    // outputs move only on scan ticks; twelve scans cover averaging
    task automatic settle;
        repeat (SETTLE) @(posedge i_clk);
        @(negedge i_clk);
    endtask

    function automatic logic [31:0] scl(input logic [10:0] g,
        input logic [10:0] b, input logic bn, input logic sn);
        return {2'b00, sn, bn, 1'b0, b, 5'h00, g};
    endfunction

    function automatic logic [31:0] ain(input logic [1:0] t,
        input logic off, input logic [2:0] src);
        return {8'h00, 8'h01, 8'h01, 1'b0, src, 1'b0, off, t};
    endfunction

    task automatic rly(input logic [3:0] md, input logic [15:0] fo,
        input logic [15:0] fs, input logic ot, input logic top,
        input logic exp);
        wr(`TIO_A_RELAY, {28'h0, md});
        wr(`TIO_A_XSTR, {28'h0, md});
        @(posedge i_clk);
        drv.fout <= fo;
        drv.fset <= fs;
        over_torque <= ot;
        count_top <= top;
        settle();
        chk({31'h0, o_relay}, {31'h0, exp});
        chk({31'h0, o_xstr}, {31'h0, exp});
    endtask

    task automatic ana(input logic [11:0] v, input logic [11:0] c);
        @(posedge i_clk);
        volt <= v;
        cur <= c;
        settle();
    endtask

    initial begin
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        wr(`TIO_A_POL, {16'h0, 8'h02, 8'h15});
        wr(`TIO_A_REACH, 32'd50000);
        wr(`TIO_A_BAND, 32'd5000);
        rchk(`TIO_A_REACH, 32'd40000);
        rchk(`TIO_A_BAND, 32'd3000);
        rchk(4'hc, 32'h0);
        wr(`TIO_A_REACH, 32'd10000);
        wr(`TIO_A_BAND, 32'd100);
        rchk(`TIO_A_REACH, 32'd10000);
        // scan counts clamp to 1 to 100
        wr(`TIO_A_AIN, 32'h00c80000);
        rchk(`TIO_A_AIN, 32'h00640100);
        // digital polarity: inputs one to five, then input six
        @(posedge i_clk);
        closed <= 6'h03;
        settle();
        chk({26'h0, o_din}, 32'h16);
        wr(`TIO_A_POL, {16'h0, 8'h02, 8'h20});
        @(posedge i_clk);
        closed <= 6'h21;
        settle();
        chk({26'h0, o_din}, 32'h01);
        // relay modes, inside and outside each band, edges of reach
        rly(4'h2, 16'd10050, 16'd10000, 1'b0, 1'b0, 1'b1);
        rly(4'h2, 16'd12000, 16'd10000, 1'b0, 1'b0, 1'b0);
        rly(4'h3, 16'd9950, 16'd0, 1'b0, 1'b0, 1'b1);
        rly(4'h3, 16'd10200, 16'd0, 1'b0, 1'b0, 1'b0);
        rly(4'h4, 16'd10001, 16'd0, 1'b0, 1'b0, 1'b1);
        rly(4'h4, 16'd10000, 16'd0, 1'b0, 1'b0, 1'b0);
        rly(4'h5, 16'd9999, 16'd0, 1'b0, 1'b0, 1'b1);
        rly(4'h5, 16'd10000, 16'd0, 1'b0, 1'b0, 1'b0);
        rly(4'hc, 16'd0, 16'd0, 1'b1, 1'b0, 1'b1);
        rly(4'hc, 16'd0, 16'd0, 1'b0, 1'b1, 1'b0);
        rly(4'hd, 16'd0, 16'd0, 1'b0, 1'b1, 1'b1);
        rly(4'hd, 16'd0, 16'd0, 1'b1, 1'b0, 1'b0);
        // voltage input scaling
        wr(`TIO_A_AIN, ain(2'd0, 1'b0, 3'd2));
        wr(`TIO_A_VSCL, scl(11'd100, 11'd0, 1'b0, 1'b0));
        wr(`TIO_A_CSCL, scl(11'd100, 11'd0, 1'b0, 1'b0));
        ana(12'h800, 12'h600);
        chk({20'h0, o_volt_ref}, 32'h800);
        chk({20'h0, o_cur_feedback}, 32'h600);
        wr(`TIO_A_VSCL, scl(11'd50, 11'd0, 1'b0, 1'b0));
        ana(12'h800, 12'h600);
        chk({20'h0, o_volt_ref}, 32'h400);
        wr(`TIO_A_VSCL, scl(11'd100, 11'd0, 1'b0, 1'b1));
        ana(12'h000, 12'h600);
        chk({20'h0, o_volt_ref}, 32'hfff);
        wr(`TIO_A_VSCL, scl(11'd100, 11'd1000, 1'b0, 1'b0));
        ana(12'h000, 12'h600);
        chk({20'h0, o_volt_ref}, 32'hfff);
        wr(`TIO_A_VSCL, scl(11'd100, 11'd1000, 1'b1, 1'b0));
        ana(12'hfff, 12'h600);
        chk({20'h0, o_volt_ref}, 32'h000);
        // live zeros
        wr(`TIO_A_VSCL, scl(11'd100, 11'd0, 1'b0, 1'b0));
        wr(`TIO_A_AIN, ain(2'd3, 1'b0, 3'd2));
        ana(12'h333, 12'h333);
        chk({20'h0, o_volt_ref}, 32'h000);
        chk({20'h0, o_cur_feedback}, 32'h000);
        ana(12'hfff, 12'hfff);
        chk({20'h0, o_volt_ref}, 32'hfff);
        // current as offset ignores its own scaling
        wr(`TIO_A_CSCL, scl(11'd0, 11'd500, 1'b1, 1'b1));
        wr(`TIO_A_AIN, ain(2'd0, 1'b1, 3'd2));
        ana(12'h000, 12'h600);
        chk({20'h0, o_cur_offset}, 32'h600);
        // meter sources and scaling
        @(posedge i_clk);
        drv <= '{fout: 16'd0, fset: 16'd40000, vout: 12'h123,
            vbus: 12'h456, iout: 12'h789};
        for (int s = 0; s < 5; s++) begin
            wr(`TIO_A_AIN, ain(2'd0, 1'b0, s[2:0]));
            settle();
            case (s)
                0: chk({20'h0, o_meter}, 32'h000);
                1: chk({20'h0, o_meter}, 32'hfff);
                2: chk({20'h0, o_meter}, 32'h123);
                3: chk({20'h0, o_meter}, 32'h8ac);
                default: chk({20'h0, o_meter}, 32'h789);
            endcase
        end
        // high supply class: bus reading passes unscaled
        wr(`TIO_A_AIN, ain(2'd0, 1'b0, 3'd3));
        hv_class <= 1'b1;
        settle();
        chk({20'h0, o_meter}, 32'h456);
        wr(`TIO_A_AIN, ain(2'd0, 1'b0, 3'd4));
        wr(`TIO_A_MSCL, scl(11'd1000, 11'd0, 1'b0, 1'b0));
        settle();
        chk({20'h0, o_meter}, 32'hfff);
        wr(`TIO_A_AIN, ain(2'd0, 1'b0, 3'd0));
        wr(`TIO_A_MSCL, scl(11'd100, 11'd0, 1'b0, 1'b1));
        settle();
        chk({20'h0, o_meter}, 32'hfff);
        wr(`TIO_A_AIN, ain(2'd0, 1'b0, 3'd1));
        wr(`TIO_A_MSCL, scl(11'd100, 11'd1000, 1'b1, 1'b0));
        settle();
        chk({20'h0, o_meter}, 32'h000);
        end_of_test();
    end
endmodule
